// ---- src/spl_loader.sv ----
// Serial program loader: four-byte instruction slave for flash and EEPROM
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module spl_loader
  import spl_pkg::*;
#(
  parameter int FLASH_WAIT_CYC = FLASH_PAGE_WAIT_CYC,
  parameter int EEPROM_WAIT_CYC = EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = CHIP_ERASE_WAIT_CYC
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial programming pins
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Status
  output logic prog_mode,
  output logic operation_pending_flag
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] flash_mem [FLASH_BYTES];
  logic [7:0] flash_buf [FLASH_BUF_BYTES];
  logic [7:0] ee_mem [EE_BYTES];
  logic [7:0] ee_buf [EE_BUF_BYTES];
  logic [EE_BUF_BYTES-1:0] ee_vld_q;

  // ----------------------------------------------------------------
  // Link domain signals
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_q = '0;
  logic [FRAME_BITS-1:0] word_q = '0;
  logic [CNT_W-1:0] bit_cnt_q = '0;
  logic frame_tgl_q = 1'b0;
  logic [7:0] tx_q = '0;
  logic miso_q = 1'b0;
  logic busy_lk;
  logic ready_lk;
  logic [7:0] answer;

  // ----------------------------------------------------------------
  // System domain signals
  // ----------------------------------------------------------------
  logic pin_high_s;
  logic frame_s;
  logic frame_seen_q;
  logic frame_evt;
  logic link_clr_q;
  logic miso_oe_q;
  spl_state_e state_q;
  spl_state_e state_d;
  logic [WAIT_W-1:0] wait_q;
  logic [WAIT_W-1:0] wait_d;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [7:0] b4;
  logic allow_op;
  logic do_erase;
  logic do_ld_flash;
  logic do_wr_flash;
  logic do_wr_ee;
  logic do_ld_ee;
  logic do_wr_ee_page;
  logic [FLASH_PAGE_W-1:0] flash_page;
  logic [EE_PAGE_W-1:0] ee_page;

  // Byte four address helpers; ee_addr serves both domains, flash_byte_addr the link domain only
  function automatic logic [FLASH_WAW:0] flash_byte_addr(input logic [7:0] hi,
                                                         input logic [7:0] lo,
                                                         input logic h);
    flash_byte_addr = {hi[FLASH_WAW-BYTE_BITS-1:0], lo, h};
  endfunction

  function automatic logic [EE_AW-1:0] ee_addr(input logic [7:0] hi,
                                               input logic [7:0] lo);
    ee_addr = {hi[EE_AW-BYTE_BITS-1:0], lo};
  endfunction

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  spl_sync u_pin_sync (
    .clk(clk_sys),
    .din(prog_reset_n),
    .dout(pin_high_s)
  );

  spl_sync u_frame_sync (
    .clk(clk_sys),
    .din(frame_tgl_q),
    .dout(frame_s)
  );

  spl_sync u_busy_sync (
    .clk(sck),
    .din(operation_pending_flag),
    .dout(busy_lk)
  );

  spl_sync u_ready_sync (
    .clk(sck),
    .din(prog_mode),
    .dout(ready_lk)
  );

  // ----------------------------------------------------------------
  // Link receive
  // ----------------------------------------------------------------
  // Bit counter; cleared at once while the reset pin stands high, even with a still clock
  always_ff @(posedge sck or posedge link_clr_q) begin
    if (link_clr_q) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Shift in MSB first; the toggle is never reset so no false frame follows a clear
  always_ff @(posedge sck) begin
    shift_q <= {shift_q[FRAME_BITS-2:0], mosi};
    if (bit_cnt_q == CNT_LAST) begin
      word_q <= {shift_q[FRAME_BITS-2:0], mosi};
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Answer for byte four; memories are static while a read is in flight
  always_comb begin
    answer = shift_q[7:0];
    if (ready_lk) begin
      if (shift_q[23:20] == OP_RD_FLASH_HI && shift_q[18:16] == OP_H_LOW_ZERO) begin
        answer = flash_mem[flash_byte_addr(shift_q[15:8], shift_q[7:0],
                                           shift_q[16+H_BIT])];
      end else if (shift_q[23:16] == OP_RD_EE) begin
        answer = ee_mem[ee_addr(shift_q[15:8], shift_q[7:0])];
      end else if (shift_q[23:16] == OP_POLL) begin
        answer = {7'h00, busy_lk};
      end
    end
  end

  // ----------------------------------------------------------------
  // Link transmit
  // ----------------------------------------------------------------
  // Byte boundaries load the previous byte as echo, or the answer
  always_ff @(negedge sck or posedge link_clr_q) begin
    if (link_clr_q) begin
      miso_q <= 1'b0;
      tx_q <= '0;
    end else if (bit_cnt_q == CNT_ANSWER) begin
      miso_q <= answer[7];
      tx_q <= {answer[6:0], 1'b0};
    end else if (bit_cnt_q[2:0] == 3'h0) begin
      miso_q <= shift_q[7];
      tx_q <= {shift_q[6:0], 1'b0};
    end else begin
      miso_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign miso = miso_q;

  // ----------------------------------------------------------------
  // Frame hand-over into the system domain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_seen_q <= 1'b0;
    end else begin
      frame_seen_q <= frame_s;
    end
  end

  assign frame_evt = frame_s != frame_seen_q;
  assign b1 = word_q[31:24];
  assign b2 = word_q[23:16];
  assign b3 = word_q[15:8];
  assign b4 = word_q[7:0];

  // Link clear and pin drive follow the reset pin level
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link_clr_q <= 1'b1;
      miso_oe_q <= 1'b0;
    end else begin
      link_clr_q <= pin_high_s;
      miso_oe_q <= ~pin_high_s;
    end
  end

  assign miso_oe = miso_oe_q;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  assign allow_op = frame_evt && state_q == SPL_READY;
  assign do_erase = allow_op && b1 == OP_ENABLE && b2[7:5] == OP_ERASE_KEY;
  assign do_ld_flash = allow_op && b1[7:4] == OP_LD_FLASH_HI
                       && b1[2:0] == OP_H_LOW_ZERO;
  assign do_wr_flash = allow_op && b1 == OP_WR_FLASH_PAGE;
  assign do_wr_ee = allow_op && b1 == OP_WR_EE;
  assign do_ld_ee = allow_op && b1 == OP_LD_EE;
  assign do_wr_ee_page = allow_op && b1 == OP_WR_EE_PAGE;
  assign flash_page = {b2[FLASH_PAGE_W-3:0], b3[7:6]};
  assign ee_page = {b2[EE_AW-BYTE_BITS-1:0], b3[7:EE_OFS_W]};

  // Next state and busy time
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      SPL_LOCKED: begin
        if (frame_evt && b1 == OP_ENABLE && b2 == OP_ENABLE_KEY) begin
          state_d = SPL_READY;
        end
      end
      SPL_READY: begin
        if (do_erase) begin
          state_d = SPL_BUSY;
          wait_d = WAIT_W'(ERASE_WAIT_CYC);
        end else if (do_wr_flash) begin
          state_d = SPL_BUSY;
          wait_d = WAIT_W'(FLASH_WAIT_CYC);
        end else if (do_wr_ee || do_wr_ee_page) begin
          state_d = SPL_BUSY;
          wait_d = WAIT_W'(EEPROM_WAIT_CYC);
        end
      end
      SPL_BUSY: begin
        if (wait_q <= 17'h00001) begin
          state_d = SPL_READY;
          wait_d = '0;
        end else begin
          wait_d = wait_q - 17'h00001;
        end
      end
      default: begin
        state_d = SPL_LOCKED;
      end
    endcase
  end

  // State register; reset pin high drops programming mode
  always_ff @(posedge clk_sys) begin
    if (reset || pin_high_s) begin
      state_q <= SPL_LOCKED;
      wait_q <= '0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
    end
  end

  // Status outputs registered from the next state
  always_ff @(posedge clk_sys) begin
    if (reset || pin_high_s) begin
      prog_mode <= 1'b0;
      operation_pending_flag <= 1'b0;
    end else begin
      prog_mode <= state_d != SPL_LOCKED;
      operation_pending_flag <= state_d == SPL_BUSY;
    end
  end

  // ----------------------------------------------------------------
  // Flash page buffer and array
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (do_ld_flash) begin
      flash_buf[{b3[FLASH_PAGE_OFS_W-1:0], b1[H_BIT]}] <= b4;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_erase) begin
      for (int i = 0; i < FLASH_BYTES; i++) begin
        flash_mem[i] <= ERASED_BYTE;
      end
    end else if (do_wr_flash) begin
      for (int i = 0; i < FLASH_BUF_BYTES; i++) begin
        flash_mem[{flash_page, 7'(i)}] <= flash_buf[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // EEPROM page buffer and array
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (do_ld_ee) begin
      ee_buf[b3[EE_OFS_W-1:0]] <= b4;
    end
  end

  // Loaded marks; a new load wins over the clearing page write
  always_ff @(posedge clk_sys) begin
    if (reset || pin_high_s) begin
      ee_vld_q <= '0;
    end else if (do_ld_ee) begin
      ee_vld_q[b3[EE_OFS_W-1:0]] <= 1'b1;
    end else if (do_wr_ee_page) begin
      ee_vld_q <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_erase) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        ee_mem[i] <= ERASED_BYTE;
      end
    end else if (do_wr_ee) begin
      ee_mem[ee_addr(b2, b3)] <= b4;
    end else if (do_wr_ee_page) begin
      for (int j = 0; j < EE_BUF_BYTES; j++) begin
        if (ee_vld_q[j]) begin
          ee_mem[{ee_page, 2'(j)}] <= ee_buf[j];
        end
      end
    end
  end

endmodule

// ---- src/spl_pkg.sv ----
// Constants, opcodes and types shared by the serial program loader
package spl_pkg;

  // ----------------------------------------------------------------
  // Clock and wait times
  // ----------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 10;
  localparam int FLASH_PAGE_WAIT_US = 4500;
  localparam int EEPROM_WRITE_WAIT_US = 9000;
  localparam int CHIP_ERASE_WAIT_US = 9000;
  localparam int FLASH_PAGE_WAIT_CYC = FLASH_PAGE_WAIT_US * CLK_SYS_MHZ;
  localparam int EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_US * CLK_SYS_MHZ;
  localparam int CHIP_ERASE_WAIT_CYC = CHIP_ERASE_WAIT_US * CLK_SYS_MHZ;
  localparam int WAIT_W = 17;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h1F;
  localparam logic [CNT_W-1:0] CNT_ECHO = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ANSWER = 5'h18;
  localparam int BYTE_BITS = 8;
  localparam int H_BIT = 3;

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int FLASH_WAW = 14;
  localparam int FLASH_PAGE_OFS_W = 6;
  localparam int FLASH_PAGE_W = 8;
  localparam int FLASH_BYTES = 32768;
  localparam int FLASH_BUF_BYTES = 128;
  localparam int EE_AW = 10;
  localparam int EE_OFS_W = 2;
  localparam int EE_PAGE_W = 8;
  localparam int EE_BYTES = 1024;
  localparam int EE_BUF_BYTES = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE = 8'hAC;
  localparam logic [7:0] OP_ENABLE_KEY = 8'h53;
  localparam logic [2:0] OP_ERASE_KEY = 3'h4;
  localparam logic [3:0] OP_RD_FLASH_HI = 4'h2;
  localparam logic [3:0] OP_LD_FLASH_HI = 4'h4;
  localparam logic [2:0] OP_H_LOW_ZERO = 3'h0;
  localparam logic [7:0] OP_WR_FLASH_PAGE = 8'h4C;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_LD_EE = 8'hC1;
  localparam logic [7:0] OP_WR_EE_PAGE = 8'hC2;
  localparam logic [7:0] OP_POLL = 8'hF0;

  // ----------------------------------------------------------------
  // Programming state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPL_LOCKED = 3'b001,
    SPL_READY = 3'b010,
    SPL_BUSY = 3'b100
  } spl_state_e;

endpackage

// ---- src/spl_sync.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module spl_sync (
  // Destination clock
  input wire logic clk,
  // Asynchronous level in, synchronised level out
  input wire logic din,
  output logic dout
);

  logic meta_q = 1'b0;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end

endmodule

// ---- dv/spl_loader_properties.sv ----
// Port assertions for the serial program loader
`timescale 1ns/1ps
module spl_loader_chk
  import spl_pkg::*;
#(
  parameter int FLASH_WAIT_CYC = FLASH_PAGE_WAIT_CYC,
  parameter int EEPROM_WAIT_CYC = EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = CHIP_ERASE_WAIT_CYC
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Link pins
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic miso,
  // Output enable and status
  input wire logic miso_oe,
  input wire logic prog_mode,
  input wire logic operation_pending_flag
);
  int busy_cnt_q;

  // Length of the current self-timed stretch
  always_ff @(posedge clk_sys) begin
    if (reset || !operation_pending_flag) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Reset pin held steady long enough to pass the synchroniser
  sequence pin_low;
    (!prog_reset_n) [*5];
  endsequence
  sequence pin_high;
    prog_reset_n [*5];
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !prog_mode && !miso_oe && !operation_pending_flag)
    else $error("status not cleared by reset");
  a_enable_first: assert property (
    $rose(prog_mode) |-> !prog_reset_n && $past(!prog_reset_n, 4))
    else $error("programming mode entered with reset pin high");
  a_pin_exits: assert property (pin_high |=> !prog_mode && !miso_oe)
    else $error("reset pin high did not end programming");
  a_oe_follows: assert property (pin_low |=> miso_oe)
    else $error("serial output not driven while pin low");
  a_mode_holds: assert property (pin_low ##0 prog_mode |=> prog_mode)
    else $error("programming mode lost while pin low");
  a_busy_enabled: assert property ($rose(operation_pending_flag) |-> prog_mode)
    else $error("write started outside programming mode");
  a_busy_length: assert property (
    $fell(operation_pending_flag) && !$past(reset) |->
      busy_cnt_q >= FLASH_WAIT_CYC && busy_cnt_q <= ERASE_WAIT_CYC + 4)
    else $error("self-timed wait of wrong length");
  a_miso_falling: assert property ($changed(miso) |-> !sck)
    else $error("serial output changed while clock high");
endmodule

bind spl_loader spl_loader_chk #(
  .FLASH_WAIT_CYC(FLASH_WAIT_CYC),
  .EEPROM_WAIT_CYC(EEPROM_WAIT_CYC),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC)
) u_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .prog_reset_n(prog_reset_n),
  .sck(sck),
  .miso(miso),
  .miso_oe(miso_oe),
  .prog_mode(prog_mode),
  .operation_pending_flag(operation_pending_flag)
);

// ---- dv/spl_prog_model.sv ----
// Behavioural serial programmer driving the loader's link pins
`timescale 1ns/1ps
module spl_prog_model #(
  parameter int HALF = 7,
  parameter int PWRUP_WAIT = 40
) (
  // Link base clock and returned data
  input wire logic clk_link,
  input wire logic miso,
  // Pins towards the device
  output logic sck,
  output logic mosi,
  output logic prog_reset_n
);
  // Power-up levels: reset pin and serial clock low
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    prog_reset_n = 1'b0;
  end

  // Wait a number of base clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_link);
  endtask

  // Settle time before the first instruction
  task automatic powerup();
    tick(PWRUP_WAIT);
  endtask

  // Positive reset pulse to regain step, then settle again
  task automatic pulse();
    @(posedge clk_link);
    prog_reset_n <= 1'b1;
    tick(12);
    prog_reset_n <= 1'b0;
    tick(PWRUP_WAIT);
  endtask

  // One stray clock pulse, as from a programmer that cannot hold the clock low
  task automatic stray();
    @(posedge clk_link);
    sck <= 1'b1;
    tick(HALF);
    sck <= 1'b0;
  endtask

  // End of session: reset pin high
  task automatic release_pin();
    @(posedge clk_link);
    prog_reset_n <= 1'b1;
  endtask

  // One whole 32-bit instruction, MSB first, sampling the answer
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_link);
      mosi <= tx[i];
      tick(HALF);
      sck <= 1'b1;
      rx[i] = miso;
      tick(HALF);
      sck <= 1'b0;
    end
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the serial program loader
`timescale 1ns/1ps
module tb_top
  import spl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b1;
  logic reset = 1'b1;
  logic sck, mosi, prog_reset_n, miso, miso_oe, prog_mode, operation_pending_flag;
  int err_total = 0;
  int checks = 0;
  int seed = 23294;
  logic [9:0] notes[$];
  logic [31:0] rx_last;
  event got;
  logic [13:0] word;
  logic [9:0] ee;
  logic [7:0] pg;
  logic [7:0] dat [4];

  // System clock 100 ns, link base clock 64 ns
  always #50 clk_sys = ~clk_sys;
  always #32 clk_link = ~clk_link;

  spl_loader #(.FLASH_WAIT_CYC(400), .EEPROM_WAIT_CYC(600), .ERASE_WAIT_CYC(800)) DUT (
    .clk_sys(clk_sys), .reset(reset), .prog_reset_n(prog_reset_n), .sck(sck),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_mode(prog_mode),
    .operation_pending_flag(operation_pending_flag));
  spl_prog_model u_prog (.clk_link(clk_link), .miso(miso), .sck(sck), .mosi(mosi),
    .prog_reset_n(prog_reset_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_sys(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Send a frame; sel 1 echo byte, 2 data byte, 3 busy bit
  task automatic xfer(input logic [31:0] tx, input logic [7:0] exp, input logic [1:0] sel);
    logic [31:0] rx;
    u_prog.frame(tx, rx);
    if (sel != 2'd0) begin
      notes.push_back({sel, exp});
      rx_last = rx;
      -> got;
    end
  endtask

  // Busy seen, then poll once mid-wait and once after it
  task automatic busy_wait();
    wait_sys(4);
    chk(operation_pending_flag, 1'b1);
    xfer({OP_POLL, 24'h000000}, 8'h01, 2'd3);
    repeat (850) @(posedge clk_sys);
    xfer({OP_POLL, 24'h000000}, 8'h00, 2'd3);
  endtask

  // Compare each answer with the oldest note
  initial begin
    logic [9:0] n;
    forever begin
      @(got);
      n = notes.pop_front();
      chk(n[9:8] == 2'd1 ? rx_last[15:8] : n[9:8] == 2'd2 ? rx_last[7:0] :
          {7'h00, rx_last[0]}, n[7:0]);
    end
  end

  // Watchdog
  initial begin
    #5000000;
    err_total++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    u_prog.powerup();
    chk(miso_oe, 1'b1);
    xfer({OP_ENABLE, 8'h80, 16'h0000}, 8'h00, 2'd0);
    wait_sys(6);
    chk(operation_pending_flag, 1'b0);
    xfer({OP_ENABLE, 8'h35, 16'h0000}, 8'h35, 2'd1);
    wait_sys(6);
    chk(prog_mode, 1'b0);
    u_prog.stray();
    u_prog.pulse();
    xfer({OP_ENABLE, OP_ENABLE_KEY, 16'h0000}, OP_ENABLE_KEY, 2'd1);
    wait_sys(6);
    chk(prog_mode, 1'b1);
    xfer({OP_ENABLE, 8'h9F, 16'hFFFF}, 8'h9F, 2'd1);
    busy_wait();
    word = 14'($random(seed));
    ee = 10'($random(seed));
    xfer({8'h28, 2'b00, word, 8'h00}, ERASED_BYTE, 2'd2);
    xfer({OP_RD_EE, 6'h00, ee, 8'h00}, ERASED_BYTE, 2'd2);
    pg = 8'($random(seed));
    for (int k = 0; k < 4; k++) begin
      dat[k] = 8'($random(seed));
      xfer({OP_LD_FLASH_HI, k[0], OP_H_LOW_ZERO, 10'h000, {6{k[1]}}, dat[k]}, 8'h00, 2'd0);
    end
    xfer({OP_WR_FLASH_PAGE, 2'b00, pg, 6'h00, 8'h00}, 8'h00, 2'd0);
    busy_wait();
    for (int k = 0; k < 4; k++) begin
      xfer({OP_RD_FLASH_HI, k[0], OP_H_LOW_ZERO, 2'b00, pg, {6{k[1]}}, 8'h00},
           dat[k], 2'd2);
    end
    for (int k = 0; k < 2; k++) begin
      dat[k] = k ? ~dat[0] : 8'($random(seed));
      xfer({OP_WR_EE, 6'h00, ee, dat[k]}, 8'h00, 2'd0);
      busy_wait();
      xfer({OP_RD_EE, 6'h00, ee, 8'h00}, dat[k], 2'd2);
    end
    pg = ee[9:2] ^ 8'h01;
    dat[2] = 8'($random(seed));
    xfer({OP_LD_EE, 14'h0000, 2'd2, dat[2]}, 8'h00, 2'd0);
    xfer({OP_WR_EE_PAGE, 6'h00, pg, 2'b00, 8'h00}, 8'h00, 2'd0);
    busy_wait();
    for (int k = 0; k < 4; k++) begin
      xfer({OP_RD_EE, 6'h00, pg, k[1:0], 8'h00}, k == 2 ? dat[2] : ERASED_BYTE, 2'd2);
    end
    u_prog.release_pin();
    wait_sys(8);
    chk({prog_mode, miso_oe}, 2'b00);
    complete_run();
  end
endmodule
